// ==== nvc_pkg.sv ====
// Package: register map, field layout and encodings of the flash config block
package nvc_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_FLASH_PARAMETERS = 8'h08;
   localparam logic [7:0] OFS_EN_CLR = 8'h0c;
   localparam logic [7:0] OFS_EN_SET = 8'h10;
   // Control register fields
   localparam int CACHE_OFF_BIT = 18;
   localparam int POLICY_LO = 16;
   localparam int SLEEP_LO = 8;
   localparam int EXPLICIT_BIT = 7;
   localparam int WAIT_LO = 1;
   localparam int WAIT_W = 4;
   localparam logic [31:0] CTRL_MASK = 32'h0007_039e;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Parameter register fields
   localparam int PAGE_CODE_LO = 16;
   // Event enable bits
   localparam int EN_W = 2;
   localparam int EN_ERROR = 1;
   localparam int EN_READY = 0;
   localparam logic [1:0] EN_RESET = 2'h0;
   // Miss policy codes
   localparam logic [1:0] POL_FAST = 2'h0;
   localparam logic [1:0] POL_SAVING = 2'h1;
   localparam logic [1:0] POL_EQUAL = 2'h2;
   // Sleep saving codes
   localparam logic [1:0] SLP_FIRST_FETCH = 2'h0;
   localparam logic [1:0] SLP_SLEEP_EXIT = 2'h1;
   localparam logic [1:0] SLP_OFF = 2'h3;
   localparam logic [4:0] ONE_WAIT = 5'h01;
   typedef enum logic {FS_IDLE, FS_WAIT} nvc_fetch_t;
endpackage

// ==== nvc_cfg.sv ====
// Flash controller configuration, fetch timing and event-enable registers
//
// Contract
// - Cache is off while control bit 18 is one, on while zero.
// - Miss policy 0: no extra wait on a cache miss.
// - Miss policy 1: one extra wait state on each cache miss.
// - Miss policy 2: hit and miss both take the programmed wait count.
// - Sleep saving 0: low power on sleep entry, left on first fetch.
// - Sleep saving 1: low power on sleep entry, left at sleep exit.
// - Sleep saving 3: no automatic low power; code 2 reserved.
// - Auto mode: last page buffer word write starts page programming.
// - Every flash read adds the 4-bit wait count, 0 to 15; here a cache hit with cache on under policy 0 or 1 adds none.
// - Wait count resets to zero; software tunes it to the clock.
// - Reserved bits read zero; software writes them as zero.
// - Page size field 18:16 encodes 8 bytes shifted by its value.
// - Bits 15:0 of the parameter register give the page count.
// - Enable registers: error enable bit 1, ready enable bit 0.
// - Writing one at 0x0c clears that enable.
// - Writing one at 0x10 sets that enable.
// - Writing zero to either enable register changes nothing.
// - Reading either enable register returns the present enables.
// - Both views share one enable state.
// - Enables reset to zero.
// - Error flag raised on any operation, lock or command error.
// - Ready flag is one when idle, zero while erasing or programming.
`timescale 1ns/1ps
`default_nettype none
module nvc_cfg
   import nvc_pkg::*;
#(
   parameter logic [2:0] PAGE_BYTES_CODE = 3'h3,
   parameter logic [15:0] PAGE_COUNT = 16'h0100
) (
   input wire logic SYS_CLK_I,
   input wire logic RESET_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic FETCH_REQ_I,
   input wire logic CACHE_HIT_I,
   output logic FETCH_DONE_O,
   output logic CACHE_OFF_O,
   output logic [1:0] MISS_POLICY_O,
   output logic [WAIT_W-1:0] READ_WAIT_COUNT_O,
   input wire logic SLEEP_I,
   output logic LOW_POWER_O,
   input wire logic PAGE_LAST_WORD_WR_I,
   output logic PAGE_PROGRAM_START_O,
   input wire logic OP_ERROR_I,
   input wire logic LOCK_ERROR_I,
   input wire logic CMD_ERROR_I,
   input wire logic ERROR_FLAG_CLR_I,
   input wire logic BUSY_I,
   output logic ERROR_FLAG_O,
   output logic READY_FLAG_O,
   output logic IRQ_O
);
   logic [31:0] ctrl_reg, ctrl_next;
   logic [EN_W-1:0] en_reg, en_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ready_reg, ready_next, err_next;
   logic acc, wr_stb, hit_ok;
   logic [1:0] pol, slp;
   logic [4:0] waits, cnt_reg, cnt_next;
   nvc_fetch_t fs_reg, fs_next;
   logic done_reg, done_next;
   logic lp_reg, lp_next, sleep_reg, sleep_next;
   logic prog_reg, prog_next;
   logic eflag_reg, eflag_next, rflag_reg, rflag_next, irq_reg, irq_next;

   ////////////////////////////////////////////////////////////////////////
   // Register slave, one wait state per access
   assign acc = PSEL_I && PENABLE_I && !ready_reg;
   assign wr_stb = acc && PWRITE_I;
   assign pol = ctrl_reg[POLICY_LO +: 2];
   assign slp = ctrl_reg[SLEEP_LO +: 2];

   // Next values of the register file and bus answer
   always_comb begin
      ctrl_next = ctrl_reg;
      en_next = en_reg;
      rdata_next = rdata_reg;
      ready_next = acc;
      err_next = 1'b0;
      if (acc) begin
         rdata_next = 32'h0;
         unique case (PADDR_I)
            OFS_CTRL: begin
               if (wr_stb) begin
                  ctrl_next = PWDATA_I & CTRL_MASK;
               end
               rdata_next = ctrl_reg;
            end
            OFS_FLASH_PARAMETERS: begin
               rdata_next = {13'h0, PAGE_BYTES_CODE, PAGE_COUNT};
            end
            OFS_EN_CLR: begin
               if (wr_stb) begin
                  en_next = en_reg & ~PWDATA_I[EN_W-1:0];
               end
               rdata_next = {30'h0, en_reg};
            end
            OFS_EN_SET: begin
               if (wr_stb) begin
                  en_next = en_reg | PWDATA_I[EN_W-1:0];
               end
               rdata_next = {30'h0, en_reg};
            end
            default: begin
               err_next = 1'b1; // Unmapped offset
            end
         endcase
      end
   end
   // Register file state
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         ctrl_reg <= CTRL_RESET;
         en_reg <= EN_RESET;
         rdata_reg <= 32'h0;
         ready_reg <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         en_reg <= en_next;
         rdata_reg <= rdata_next;
         ready_reg <= ready_next;
         PSLVERR_O <= err_next;
      end
   end
   assign PRDATA_O = rdata_reg;
   assign PREADY_O = ready_reg;
   assign CACHE_OFF_O = ctrl_reg[CACHE_OFF_BIT];
   assign MISS_POLICY_O = pol;
   assign READ_WAIT_COUNT_O = ctrl_reg[WAIT_LO +: WAIT_W];

   ////////////////////////////////////////////////////////////////////////
   // Fetch timing: a hit is free only with the cache on and policy not 2
   assign hit_ok = CACHE_HIT_I && !ctrl_reg[CACHE_OFF_BIT];
   always_comb begin
      waits = {1'b0, ctrl_reg[WAIT_LO +: WAIT_W]};
      if (pol != POL_EQUAL && hit_ok) begin
         waits = 5'h0;
      end else if (pol == POL_SAVING) begin
         waits = waits + ONE_WAIT;
      end
   end
   // Fetch counter; done pulses 1 + waits cycles after the request
   always_comb begin
      fs_next = fs_reg;
      cnt_next = cnt_reg;
      done_next = 1'b0;
      unique case (fs_reg)
         FS_IDLE: begin
            if (FETCH_REQ_I) begin
               if (waits == 5'h0) begin
                  done_next = 1'b1;
               end else begin
                  cnt_next = waits;
                  fs_next = FS_WAIT;
               end
            end
         end
         FS_WAIT: begin
            cnt_next = cnt_reg - ONE_WAIT;
            if (cnt_reg == ONE_WAIT) begin
               done_next = 1'b1;
               fs_next = FS_IDLE;
            end
         end
      endcase
   end
   // Fetch state
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         fs_reg <= FS_IDLE;
         cnt_reg <= 5'h0;
         done_reg <= 1'b0;
      end else begin
         fs_reg <= fs_next;
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end
   assign FETCH_DONE_O = done_reg;

   ////////////////////////////////////////////////////////////////////////
   // Sleep power saving and automatic page programming
   always_comb begin
      sleep_next = SLEEP_I;
      lp_next = lp_reg;
      if (SLEEP_I && !sleep_reg && (slp == SLP_FIRST_FETCH ||
          slp == SLP_SLEEP_EXIT)) begin
         lp_next = 1'b1;
      end else if (slp == SLP_SLEEP_EXIT && !SLEEP_I && sleep_reg) begin
         lp_next = 1'b0;
      end else if (FETCH_REQ_I) begin
         lp_next = 1'b0;
      end
      // Explicit mode leaves the start to the command path
      prog_next = PAGE_LAST_WORD_WR_I && !ctrl_reg[EXPLICIT_BIT];
   end
   // Power and programming state
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         sleep_reg <= 1'b0;
         lp_reg <= 1'b0;
         prog_reg <= 1'b0;
      end else begin
         sleep_reg <= sleep_next;
         lp_reg <= lp_next;
         prog_reg <= prog_next;
      end
   end
   assign LOW_POWER_O = lp_reg;
   assign PAGE_PROGRAM_START_O = prog_reg;

   ////////////////////////////////////////////////////////////////////////
   // Event flags and interrupt; a new error beats a clear in one cycle
   always_comb begin
      eflag_next = eflag_reg;
      if (ERROR_FLAG_CLR_I) begin
         eflag_next = 1'b0;
      end
      if (OP_ERROR_I || LOCK_ERROR_I || CMD_ERROR_I) begin
         eflag_next = 1'b1;
      end
      rflag_next = !BUSY_I;
      irq_next = (eflag_next && en_next[EN_ERROR]) ||
         (rflag_next && en_next[EN_READY]);
   end
   // Flag state
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         eflag_reg <= 1'b0;
         rflag_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         eflag_reg <= eflag_next;
         rflag_reg <= rflag_next;
         irq_reg <= irq_next;
      end
   end
   assign ERROR_FLAG_O = eflag_reg;
   assign READY_FLAG_O = rflag_reg;
   assign IRQ_O = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence s_req_idle;
      FETCH_REQ_I && fs_reg == FS_IDLE;
   endsequence
   property p_cache_off;
      wr_stb && PADDR_I == OFS_CTRL |=>
         CACHE_OFF_O == $past(PWDATA_I[CACHE_OFF_BIT]);
   endproperty
   a_cache_off: assert property (p_cache_off)
      else $error("cache off bit not taken");
   property p_fast_hit;
      s_req_idle ##0 (pol == POL_FAST && hit_ok) |=> FETCH_DONE_O;
   endproperty
   a_fast_hit: assert property (p_fast_hit)
      else $error("hit did not finish at once");
   property p_saving_miss;
      s_req_idle ##0 (pol == POL_SAVING && !hit_ok &&
         READ_WAIT_COUNT_O == 4'h0) |=> !FETCH_DONE_O ##1 FETCH_DONE_O;
   endproperty
   a_saving_miss: assert property (p_saving_miss)
      else $error("miss lacks one extra wait");
   property p_equal;
      s_req_idle ##0 (pol == POL_EQUAL && READ_WAIT_COUNT_O == 4'h2)
         |=> !FETCH_DONE_O [*2] ##1 FETCH_DONE_O;
   endproperty
   a_equal: assert property (p_equal)
      else $error("equal policy timing wrong");
   property p_wait_count;
      s_req_idle ##0 (CACHE_OFF_O && pol == POL_FAST && READ_WAIT_COUNT_O ==
         4'h3) |=> !FETCH_DONE_O [*3] ##1 FETCH_DONE_O;
   endproperty
   a_wait_count: assert property (p_wait_count)
      else $error("wait count not applied");
   // Any fetch that is not itself a sleep entry ends the saving
   property p_first_fetch;
      LOW_POWER_O && FETCH_REQ_I && (sleep_reg || !SLEEP_I) |=>
         !LOW_POWER_O;
   endproperty
   a_first_fetch: assert property (p_first_fetch)
      else $error("fetch did not leave low power");
   property p_sleep_exit;
      slp == SLP_SLEEP_EXIT && $fell(SLEEP_I) |=> !LOW_POWER_O;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit)
      else $error("sleep exit did not leave low power");
   property p_saving_off;
      slp == SLP_OFF && !LOW_POWER_O |=> !LOW_POWER_O;
   endproperty
   a_saving_off: assert property (p_saving_off)
      else $error("low power entered while disabled");
   property p_auto_prog;
      PAGE_LAST_WORD_WR_I |=>
         PAGE_PROGRAM_START_O == $past(!ctrl_reg[EXPLICIT_BIT]);
   endproperty
   a_auto_prog: assert property (p_auto_prog)
      else $error("page program start wrong");
   property p_en_set;
      wr_stb && PADDR_I == OFS_EN_SET |=>
         en_reg == ($past(en_reg) | $past(PWDATA_I[EN_W-1:0]));
   endproperty
   a_en_set: assert property (p_en_set)
      else $error("enable set wrong");
   property p_en_clr;
      wr_stb && PADDR_I == OFS_EN_CLR |=>
         en_reg == ($past(en_reg) & ~$past(PWDATA_I[EN_W-1:0]));
   endproperty
   a_en_clr: assert property (p_en_clr)
      else $error("enable clear wrong");
   property p_err_wins;
      (OP_ERROR_I || LOCK_ERROR_I || CMD_ERROR_I) |=> ERROR_FLAG_O;
   endproperty
   a_err_wins: assert property (p_err_wins)
      else $error("error event lost");
   property p_irq;
      ##1 IRQ_O == ((ERROR_FLAG_O && en_reg[EN_ERROR]) ||
         (READY_FLAG_O && en_reg[EN_READY]));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt does not match flags");
endmodule
`default_nettype wire

// ==== nvc_fetch_model.sv ====
// Far-side fetch path model: issues one fetch and times it
`timescale 1ns/1ps
`default_nettype none
module nvc_fetch_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic hit_i,
   input wire logic done_i,
   output logic req_o,
   output logic hit_o,
   output logic fin_o,
   output int lat_o
);
   int n;
   // Quiet lines until the first fetch
   initial begin
      req_o = 1'b0;
      hit_o = 1'b0;
      fin_o = 1'b0;
      lat_o = 0;
   end
   ////////////////////////////////////////////////////////////////////////
   // One request pulse, hit held until done, then scrambled
   always @(posedge clk_i) begin
      if (go_i === 1'b1) begin
         #2;
         req_o = 1'b1;
         hit_o = hit_i;
         @(posedge clk_i);
         #2;
         req_o = 1'b0;
         n = 0;
         // Bounded so a dead design still yields a latency
         while (done_i !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            #2;
            n++;
         end
         // Done is seen just after its launch; count its sampling edge
         lat_o = n + 1;
         fin_o = 1'b1;
         // Qualifier no longer valid: do not show the old value
         hit_o = ~hit_o;
         @(posedge clk_i);
         #2;
         fin_o = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== nvc_cfg_tb.sv ====
// Testbench: registers, fetch timing, sleep, page program and events
`timescale 1ns/1ps
`default_nettype none
module nvc_cfg_tb
   import nvc_pkg::*;
;
   localparam logic [2:0] PBC = 3'h5;
   localparam logic [15:0] PCT = 16'h0040;
   localparam logic WR = 1'b1;
   localparam logic RD = 1'b0;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, req, hit, done, c_off, lowp, sleep = 1'b0;
   logic go = 1'b0, ghit = 1'b0, fin, plw = 1'b0, pstart, eclr = 1'b0;
   logic busy = 1'b0, eflag, rflag, irq;
   logic [2:0] errv = 3'h0;
   logic [1:0] pol_o;
   logic [3:0] wc_o;
   int lat, n_mismatch = 0, check_count = 0, seed = 79;
   logic [33:0] qa[$];
   int qf[$];

   always #12.5 clk = ~clk;

   nvc_cfg #(.PAGE_BYTES_CODE(PBC), .PAGE_COUNT(PCT)) uut (
      .SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .FETCH_REQ_I(req), .CACHE_HIT_I(hit),
      .FETCH_DONE_O(done), .CACHE_OFF_O(c_off), .MISS_POLICY_O(pol_o),
      .READ_WAIT_COUNT_O(wc_o), .SLEEP_I(sleep), .LOW_POWER_O(lowp),
      .PAGE_LAST_WORD_WR_I(plw), .PAGE_PROGRAM_START_O(pstart),
      .OP_ERROR_I(errv[0]), .LOCK_ERROR_I(errv[1]),
      .CMD_ERROR_I(errv[2]), .ERROR_FLAG_CLR_I(eclr), .BUSY_I(busy),
      .ERROR_FLAG_O(eflag), .READY_FLAG_O(rflag), .IRQ_O(irq));

   nvc_fetch_model fm (.clk_i(clk), .go_i(go), .hit_i(ghit),
      .done_i(done), .req_o(req), .hit_o(hit), .fin_o(fin), .lat_o(lat));

   ////////////////////////////////////////////////////////////////////////
   // Step n edges, landing just after the last one
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clk);
         #2;
      end
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask

   task automatic final_report();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Bus access: request held until the edge that sees ready
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] e,
                      input logic er);
      int i;
      qa.push_back({~w, er, e});
      tk(1);
      psel = 1'b1;
      pwr = w;
      paddr = a;
      pwdata = d;
      tk(1);
      pen = 1'b1;
      for (i = 0; i < 10 && pready !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (pready !== 1'b1) begin
         n_mismatch++;
         final_report();
      end
      tk(1);
      psel = 1'b0;
      pen = 1'b0;
   endtask

   // One fetch through the far-side model, latency noted first
   task automatic fch(input logic off, input logic [1:0] pl,
                      input logic h, input logic [3:0] w);
      int i;
      qf.push_back(((h && !off && pl != POL_EQUAL) ? 0 :
                    w + (pl == POL_SAVING)) + 1);
      ghit = h;
      go = 1'b1;
      tk(1);
      go = 1'b0;
      // Look mid-cycle: the finish pulse may rise in the drive time step
      for (i = 0; i < 60 && fin !== 1'b1; i++) begin
         @(negedge clk);
      end
      if (fin !== 1'b1) begin
         n_mismatch++;
         final_report();
      end
      tk(2);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Monitors: oldest note against each answer as it appears
   always @(negedge clk) begin
      logic [33:0] e;
      if (pready === 1'b1) begin
         e = qa.pop_front();
         chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
         if (e[33]) begin
            chk("prdata", e[31:0], prdata);
         end
      end
      if (fin === 1'b1) begin
         chk("latency", qf.pop_front(), lat);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] r;
      logic [1:0] pl;
      logic [3:0] w;
      int k;
      tk(6);
      rst_n = 1'b1;
      bus(RD, OFS_CTRL, 32'h0, CTRL_RESET, 1'b0);
      bus(RD, OFS_EN_CLR, 32'h0, 32'h0, 1'b0);
      bus(RD, OFS_EN_SET, 32'h0, 32'h0, 1'b0);
      bus(WR, OFS_FLASH_PARAMETERS, 32'hffffffff, 32'h0, 1'b0);
      bus(RD, OFS_FLASH_PARAMETERS, 32'h0, {13'h0, PBC, PCT}, 1'b0);
      bus(RD, 8'h14, 32'h0, 32'h0, 1'b1);
      // Random word: reserved bits must read back clear
      r = $random(seed);
      bus(WR, OFS_CTRL, r, 32'h0, 1'b0);
      bus(RD, OFS_CTRL, 32'h0, r & CTRL_MASK, 1'b0);
      chk("cache_off", {31'h0, r[18]}, {31'h0, c_off});
      chk("policy", {30'h0, r[17:16]}, {30'h0, pol_o});
      chk("wait", {28'h0, r[4:1]}, {28'h0, wc_o});
      // Every policy, cache state and hit outcome; top count last
      for (k = 0; k < 12; k++) begin
         pl = 2'(k >> 2);
         // Known counts where the timing checks need them
         w = (k == 2) ? 4'h3 : (k == 4) ? 4'h0 : (k == 9) ? 4'h2 :
            (k > 9) ? 4'hf : 4'($random(seed));
         r = {13'h0, k[1], pl, 11'h0, w, 1'b0};
         bus(WR, OFS_CTRL, r, 32'h0, 1'b0);
         fch(k[1], pl, k[0], w);
      end
      // Set and clear views of one enable pair
      bus(WR, OFS_EN_SET, 32'h1, 32'h0, 1'b0);
      bus(RD, OFS_EN_CLR, 32'h0, 32'h1, 1'b0);
      bus(WR, OFS_EN_SET, 32'h2, 32'h0, 1'b0);
      bus(WR, OFS_EN_CLR, 32'h0, 32'h0, 1'b0);
      bus(WR, OFS_EN_SET, 32'h0, 32'h0, 1'b0);
      bus(RD, OFS_EN_SET, 32'h0, 32'h3, 1'b0);
      bus(WR, OFS_EN_CLR, 32'h1, 32'h0, 1'b0);
      bus(RD, OFS_EN_SET, 32'h0, 32'h2, 1'b0);
      chk("irq", 32'h0, {31'h0, irq});
      // Each error source sets the flag and the request
      for (k = 0; k < 3; k++) begin
         errv[k] = 1'b1;
         tk(1);
         errv = 3'h0;
         chk("err_flag", 32'h1, {31'h0, eflag});
         chk("irq", 32'h1, {31'h0, irq});
         eclr = 1'b1;
         tk(1);
         eclr = 1'b0;
         chk("irq", 32'h0, {31'h0, irq});
      end
      // Masked error, then ready enabled, then busy
      bus(WR, OFS_EN_CLR, 32'h2, 32'h0, 1'b0);
      errv[0] = 1'b1;
      tk(1);
      errv = 3'h0;
      chk("irq", 32'h0, {31'h0, irq});
      bus(WR, OFS_EN_SET, 32'h1, 32'h0, 1'b0);
      chk("ready", 32'h1, {31'h0, rflag});
      chk("irq", 32'h1, {31'h0, irq});
      busy = 1'b1;
      tk(2);
      chk("ready", 32'h0, {31'h0, rflag});
      chk("irq", 32'h0, {31'h0, irq});
      busy = 1'b0;
      // Sleep saving: 0 wakes on fetch, 1 at sleep exit, 3 never
      for (k = 0; k < 3; k++) begin
         pl = (k == 2) ? SLP_OFF : 2'(k);
         bus(WR, OFS_CTRL, {22'h0, pl, 8'h0}, 32'h0, 1'b0);
         sleep = 1'b1;
         tk(2);
         chk("low_power", {31'h0, k != 2}, {31'h0, lowp});
         sleep = 1'b0;
         tk(2);
         chk("low_power", {31'h0, k == 0}, {31'h0, lowp});
         fch(1'b0, POL_FAST, 1'b1, 4'h0);
         chk("low_power", 32'h0, {31'h0, lowp});
      end
      // Auto page program only while explicit mode is off
      for (k = 0; k < 2; k++) begin
         bus(WR, OFS_CTRL, {24'h0, k[0], 7'h0}, 32'h0, 1'b0);
         plw = 1'b1;
         tk(1);
         plw = 1'b0;
         chk("prog_start", {31'h0, !k[0]}, {31'h0, pstart});
      end
      final_report();
   end
endmodule
`default_nettype wire
